//--- hdl/smbh_regs.sv
// register file and line control for one serial host interface
// assumes a protocol engine on the same clock and open-drain pads outside
// Contract
// R1 - software idles first region before leaving boot
// R2 - cleared boot bit sends next fetch parallel
// R3 - boot mode may stay during relocated fetches
// R4 - each register sits in 64-bit slot
// R5 - software writes full implemented width
// R6 - serial clock is sysclk over eight times divider
// R7 - software picks 31 or 1250 for speeds
// R8 - command bytes sent after address byte
// R9 - extended reads capture received command bytes
// R10 - read gives captured, write sets outgoing
// R11 - control bit 0 gates error interrupt
// R12 - busy fall raises completion, status read clears
// R13 - control bit 7 selects direct line mode
// R14 - data driven only when direction bit set; engine mode drives data on i_eng_sda_low whatever bit 5 holds
// R15 - direct mode drives bit 6 onto clock
// R16 - status bit 0 shows transfer in progress
// R17 - writing one clears error and its interrupt
// R18 - status 6,7 show reference and data
// R19 - counter reloads every divider times four
`timescale 1ns/1ps
module smbh_regs
  import smbh_pkg::*;
#(
  parameter int INST = 0, // 0 or 1, picks the register slots
  parameter int DIV_W = SMBH_DIV_W
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // register port in the i/o space
  input wire logic [31:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [63:0] i_reg_wdata,
  output logic [63:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // protocol engine status
  input wire logic i_eng_busy,
  input wire logic i_eng_err,
  input wire logic i_eng_err_retry,
  input wire logic i_eng_scl_low,
  input wire logic i_eng_sda_low,
  // protocol engine received bytes
  input wire logic i_rx_valid,
  input wire logic i_rx_second,
  input wire logic [7:0] i_rx_byte,
  input wire logic [3:0] i_xfer_type,
  input wire logic i_xfer_ext,
  // protocol engine command bytes
  output logic [7:0] o_cmd_lo,
  output logic [7:0] o_cmd_hi,
  output logic o_scl_ref,
  // boot routing
  input wire logic i_serial_boot,
  input wire logic i_fetch_valid,
  input wire logic i_fetch_cs0,
  input wire logic i_fetch_cs1,
  output logic o_fetch_serial,
  output logic o_fetch_generic,
  // pins
  input wire logic i_sda,
  output logic o_scl,
  output logic o_scl_oe,
  output logic o_sda,
  output logic o_sda_oe,
  // interrupts
  output logic o_err_irq,
  output logic o_finish_irq
);
  // slot match on the 64-bit aligned address
  function automatic logic slot_hit(input logic [31:0] a,
                                    input logic [31:0] off);
    slot_hit = (a[31:SMBH_SLOT_LSB] == off[31:SMBH_SLOT_LSB]);
  endfunction

  // pick the slot of this instance
  function automatic logic [31:0] pick(input logic [31:0] off0,
                                       input logic [31:0] off1);
    pick = (INST == 0) ? off0 : off1;
  endfunction

  localparam logic [31:0] FREQ_OFF = pick(SMBH_FREQ_OFF_0, SMBH_FREQ_OFF_1);
  localparam logic [31:0] STAT_OFF = pick(SMBH_STAT_OFF_0, SMBH_STAT_OFF_1);
  localparam logic [31:0] CMD_OFF = pick(SMBH_CMD_OFF_0, SMBH_CMD_OFF_1);
  localparam logic [31:0] CTRL_OFF = pick(SMBH_CTRL_OFF_0, SMBH_CTRL_OFF_1);

  // software visible state
  logic [DIV_W-1:0] divider; // serial clock divider
  logic [7:0] control; // enables and direct line bits
  logic [7:0] cmd_tx_lo; // outgoing command low byte
  logic [7:0] cmd_tx_hi; // outgoing command high byte
  logic [7:0] cmd_rx_lo; // captured first byte
  logic [7:0] cmd_rx_hi; // captured second byte
  logic err_flag; // sticky error
  logic err_kind; // set on retry failure, clear on missing ack
  logic fin_flag; // sticky completion event
  logic busy_q; // busy one cycle ago
  // pin synchroniser, three stages
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;
  logic sda_level; // filtered pin level
  // reference from the clock generator
  logic scl_ref;

  // address decode, one wire per slot
  wire hit_freq = slot_hit(i_reg_addr, FREQ_OFF); // [R4]
  wire hit_stat = slot_hit(i_reg_addr, STAT_OFF); // [R4]
  wire hit_cmd = slot_hit(i_reg_addr, CMD_OFF); // [R4]
  wire hit_ctrl = slot_hit(i_reg_addr, CTRL_OFF); // [R4]

  // write strobes; only the low implemented bytes are taken, so a narrow
  // write from software loads whatever the bus holds into the upper bits of the field
  wire wr_freq = i_reg_wr & hit_freq; // [R5]
  wire wr_stat = i_reg_wr & hit_stat;
  wire wr_cmd = i_reg_wr & hit_cmd;
  wire wr_ctrl = i_reg_wr & hit_ctrl;
  wire rd_stat = i_reg_rd & hit_stat;

  // control fields
  wire direct = control[SMBH_CTL_DIRECT]; // [R13]
  wire err_en = control[SMBH_CTL_ERR_EN];
  wire fin_en = control[SMBH_CTL_FIN_EN];

  // busy falling edge marks the end of a transfer
  wire busy_fall = busy_q & ~i_eng_busy; // [R12]

  // error flag: set wins over the write-one clear
  wire err_clr = wr_stat & i_reg_wdata[SMBH_ST_ERR];
  wire next_err_flag = i_eng_err | (err_flag & ~err_clr); // [R17]

  // completion flag: set wins over the clearing status read
  wire fin_set = busy_fall & fin_en;
  wire next_fin_flag = fin_set | (fin_flag & ~rd_stat); // [R12]

  // capture conditions for extended reads
  wire ext_rd1 = i_xfer_ext & ((i_xfer_type == SMBH_TYPE_RD1)
                               | (i_xfer_type == SMBH_TYPE_RD2));
  wire ext_rd2 = i_xfer_ext & (i_xfer_type == SMBH_TYPE_RD2);
  wire cap_lo = i_rx_valid & ~i_rx_second & ext_rd1; // [R9]
  wire cap_hi = i_rx_valid & i_rx_second & ext_rd2; // [R9]

  // status word as software sees it
  logic [7:0] status;
  assign status[SMBH_ST_BUSY] = i_eng_busy; // [R16]
  assign status[SMBH_ST_ERR] = err_flag;
  assign status[SMBH_ST_ETYPE] = err_kind;
  assign status[5:3] = 3'b000; // reserved, clock pin level not offered
  assign status[SMBH_ST_REF] = direct & scl_ref; // [R18]
  assign status[SMBH_ST_SDA] = direct & sda_level; // [R18]

  // read mux; unmapped slots and unimplemented bits read zero
  wire [63:0] rd_freq = {{(64 - DIV_W){1'b0}}, divider};
  wire [63:0] rd_stat_w = {56'h0000_0000_0000_00, status};
  wire [63:0] rd_cmd = {48'h0000_0000_0000, cmd_rx_hi, cmd_rx_lo}; // [R10]
  wire [63:0] rd_ctrl = {56'h0000_0000_0000_00, control};
  wire [63:0] rd_mux = hit_freq ? rd_freq :
                       hit_stat ? rd_stat_w :
                       hit_cmd ? rd_cmd :
                       hit_ctrl ? rd_ctrl : 64'h0000_0000_0000_0000;

  // pin drive in both modes
  // direct: clock pin follows bit 6, data follows bit 4 under bit 5
  // engine: open drain, pull low on request
  wire next_scl = direct ? control[SMBH_CTL_SCL_OUT] : 1'b0; // [R15]
  wire next_scl_oe = direct ? 1'b1 : i_eng_scl_low; // [R15]
  wire next_sda = direct ? control[SMBH_CTL_SDA_OUT] : 1'b0; // [R14]
  wire next_sda_oe = direct ? control[SMBH_CTL_SDA_DIR]
                            : i_eng_sda_low; // [R14]

  // divider register, reset gives the standard speed
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      divider <= DIV_W'(SMBH_DIV_RST);
    end else if (wr_freq) begin
      divider <= i_reg_wdata[DIV_W-1:0]; // [R6]
    end
  end

  // control register, reserved bits kept at zero
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      control <= SMBH_CTL_RST; // [R11]
    end else if (wr_ctrl) begin
      control <= i_reg_wdata[7:0] & SMBH_CTL_MASK; // [R13]
    end
  end

  // outgoing command bytes, held for the next write transfer
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cmd_tx_lo <= SMBH_CMD_RST[7:0];
      cmd_tx_hi <= SMBH_CMD_RST[15:8];
    end else if (wr_cmd) begin
      cmd_tx_lo <= i_reg_wdata[7:0]; // [R10]
      cmd_tx_hi <= i_reg_wdata[15:8]; // [R10]
    end
  end

  // captured command bytes from the last extended read
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cmd_rx_lo <= SMBH_CMD_RST[7:0];
      cmd_rx_hi <= SMBH_CMD_RST[15:8];
    end else begin
      if (cap_lo) begin
        cmd_rx_lo <= i_rx_byte; // [R9]
      end
      if (cap_hi) begin
        cmd_rx_hi <= i_rx_byte; // [R9]
      end
    end
  end

  // bytes handed to the engine; it sends low after the address and
  // high only in extended mode, so both are always offered
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_cmd_lo <= SMBH_CMD_RST[7:0];
      o_cmd_hi <= SMBH_CMD_RST[15:8];
    end else begin
      o_cmd_lo <= cmd_tx_lo; // [R8]
      o_cmd_hi <= cmd_tx_hi; // [R8]
    end
  end

  // error flag and its kind
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      err_flag <= 1'b0;
      err_kind <= 1'b0;
    end else begin
      err_flag <= next_err_flag; // [R17]
      if (i_eng_err) begin
        err_kind <= i_eng_err_retry;
      end
    end
  end

  // busy history and completion flag
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      fin_flag <= 1'b0;
    end else begin
      busy_q <= i_eng_busy;
      fin_flag <= next_fin_flag; // [R12]
    end
  end

  // interrupt outputs; the error mask only gates, the flag stays; the finish mask gates the flag set
  // trade-off: one cycle after the engine event, in step with the flag, but glitch free
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_err_irq <= 1'b0;
      o_finish_irq <= 1'b0;
    end else begin
      o_err_irq <= next_err_flag & err_en; // [R11]
      o_finish_irq <= next_fin_flag; // [R12]
    end
  end

  // data pin synchroniser; stage one feeds only stage two
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // accept a level only when the last two stages agree
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sda_level <= 1'b1;
    end else if (sda_s2 == sda_s3) begin
      sda_level <= sda_s3; // [R18]
    end
  end

  // pin drivers, registered so the pads see no decode glitches
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_scl <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_scl <= next_scl;
      o_scl_oe <= next_scl_oe;
      o_sda <= next_sda;
      o_sda_oe <= next_sda_oe;
    end
  end

  // read response one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reg_rdata <= 64'h0000_0000_0000_0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux; // [R4]
      end
    end
  end

  // serial clock reference
  smbh_clkgen #(
    .DIV_W(DIV_W)
  ) u_clkgen (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_div(divider),
    .o_ref(scl_ref)
  );

  // engine copy of the reference, registered for the output rule
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_scl_ref <= 1'b0;
    end else begin
      o_scl_ref <= scl_ref; // [R6]
    end
  end

  // boot fetch routing; software must idle the region before it
  // clears the boot bit, nothing here can recover a lost fetch
  smbh_boot_steer u_steer (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_serial_boot(i_serial_boot), // [R1]
    .i_fetch_valid(i_fetch_valid),
    .i_fetch_cs0(i_fetch_cs0),
    .i_fetch_cs1(i_fetch_cs1),
    .o_fetch_serial(o_fetch_serial),
    .o_fetch_generic(o_fetch_generic)
  );
endmodule

//--- hdl/smbh_pkg.sv
// shared constants for the serial host register block
// assumes one system clock and one register port per instance
package smbh_pkg;
  // clock rates
  localparam int SMBH_SYS_CLK_HZ = 40_000_000; // actual system clock
  localparam int SMBH_REF_CLK_HZ = 100_000_000; // rate the divider was sized for
  // system clocks per divider unit in one half period of the serial clock
  localparam int SMBH_HALF_MULT = 4;

  // register slots, instance 0 and instance 1
  localparam logic [31:0] SMBH_XTRA_OFF_0 = 32'h1006_0000;
  localparam logic [31:0] SMBH_FREQ_OFF_0 = 32'h1006_0010;
  localparam logic [31:0] SMBH_FREQ_OFF_1 = 32'h1006_0018;
  localparam logic [31:0] SMBH_STAT_OFF_0 = 32'h1006_0020;
  localparam logic [31:0] SMBH_STAT_OFF_1 = 32'h1006_0028;
  localparam logic [31:0] SMBH_CMD_OFF_0 = 32'h1006_0030;
  localparam logic [31:0] SMBH_CMD_OFF_1 = 32'h1006_0038;
  localparam logic [31:0] SMBH_CTRL_OFF_0 = 32'h1006_0060;
  localparam logic [31:0] SMBH_CTRL_OFF_1 = 32'h1006_0068;
  localparam int SMBH_SLOT_LSB = 3; // each slot is 64 bits wide

  // divider field
  localparam int SMBH_DIV_W = 13;
  localparam logic [12:0] SMBH_DIV_RST = 13'h007d;

  // control bits
  localparam int SMBH_CTL_ERR_EN = 0;
  localparam int SMBH_CTL_FIN_EN = 1;
  localparam int SMBH_CTL_SDA_OUT = 4;
  localparam int SMBH_CTL_SDA_DIR = 5;
  localparam int SMBH_CTL_SCL_OUT = 6;
  localparam int SMBH_CTL_DIRECT = 7;
  localparam logic [7:0] SMBH_CTL_RST = 8'h00;
  localparam logic [7:0] SMBH_CTL_MASK = 8'hf3; // bits 3:2 reserved

  // status bits
  localparam int SMBH_ST_BUSY = 0;
  localparam int SMBH_ST_ERR = 1;
  localparam int SMBH_ST_ETYPE = 2;
  localparam int SMBH_ST_REF = 6;
  localparam int SMBH_ST_SDA = 7;

  // command bytes
  localparam logic [15:0] SMBH_CMD_RST = 16'h0000;
  localparam logic [3:0] SMBH_TYPE_RD1 = 4'h5; // first byte captured
  localparam logic [3:0] SMBH_TYPE_RD2 = 4'h6; // both bytes captured
endpackage

//--- hdl/smbh_clkgen.sv
// serial clock reference generator
// assumes the divider value comes from a register on the same clock
`timescale 1ns/1ps
module smbh_clkgen
  import smbh_pkg::*;
#(
  parameter int DIV_W = SMBH_DIV_W
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // divider from the register file
  input wire logic [DIV_W-1:0] i_div,
  // reference output
  output logic o_ref
);
  localparam int CNT_W = DIV_W + 2; // holds div times four

  logic [CNT_W-1:0] cnt; // cycles left in this half period
  logic [CNT_W-1:0] reload; // half period length
  wire div_zero = (i_div == '0);

  // zero would stall the clock, so treat it as one
  assign reload = div_zero ? CNT_W'(SMBH_HALF_MULT)
                           : CNT_W'({i_div, 2'b00}); // [R6]

  // count down, toggle on reload; a new divider takes effect at reload
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt <= '0;
      o_ref <= 1'b0;
    end else if (cnt <= CNT_W'(1)) begin
      cnt <= reload; // [R19]
      o_ref <= ~o_ref; // [R6]
    end else begin
      cnt <= cnt - CNT_W'(1);
    end
  end
endmodule

//--- hdl/smbh_boot_steer.sv
// routes first chip-select fetches to the serial or the parallel bus
// assumes the boot bit is a level from system configuration, same clock
`timescale 1ns/1ps
module smbh_boot_steer
  import smbh_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // boot mode level
  input wire logic i_serial_boot,
  // fetch request
  input wire logic i_fetch_valid,
  input wire logic i_fetch_cs0,
  input wire logic i_fetch_cs1,
  // routing pulses
  output logic o_fetch_serial,
  output logic o_fetch_generic
);
  // the level is read in the fetch cycle itself, so the first fetch
  // after the clearing write already goes to the parallel bus
  wire to_serial = i_fetch_valid & i_fetch_cs0 & i_serial_boot; // [R2]
  // second region never looks at the boot bit, so boot mode can stay on
  wire to_generic = i_fetch_valid & ((i_fetch_cs0 & ~i_serial_boot)
                                     | i_fetch_cs1); // [R3]

  // register the decisions
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_fetch_serial <= 1'b0;
      o_fetch_generic <= 1'b0;
    end else begin
      o_fetch_serial <= to_serial;
      o_fetch_generic <= to_generic;
    end
  end
endmodule

//--- bench/smbh_slave_model.sv
// far-side model: open-drain data line with pull-up and a slave
// assumes the host pad drives only while its enable is high
`timescale 1ns/1ps
module smbh_slave_model (
  // host pad drive
  input wire logic i_sda,
  input wire logic i_sda_oe,
  // slave pulls low, as for an acknowledge
  input wire logic i_hold_low,
  // resolved line level
  output logic o_line
);
  // pull-up unless any party pulls low; an unknown host drive with no slave pull gives an unknown level
  assign o_line = !(i_sda_oe && !i_sda) && !i_hold_low;
endmodule

//--- bench/smbh_regs_checker.sv
// checker for one register block: irq, status and pin relations
// assumes it is bound to smbh_regs and sees only its ports
`timescale 1ns/1ps
module smbh_regs_checker
  import smbh_pkg::*;
#(
  parameter int INST = 0
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // register port
  input wire logic [31:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [63:0] i_reg_wdata,
  input wire logic [63:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // engine and pins
  input wire logic i_eng_busy,
  input wire logic i_eng_err,
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_err_irq,
  input wire logic o_finish_irq
);
  localparam logic [31:0] STAT = INST ? SMBH_STAT_OFF_1 : SMBH_STAT_OFF_0;
  localparam logic [31:0] CTRL = INST ? SMBH_CTRL_OFF_1 : SMBH_CTRL_OFF_0;
  wire stat_hit = i_reg_addr[31:3] == STAT[31:3]; // status slot hit
  wire ctrl_wr = i_reg_wr && i_reg_addr[31:3] == CTRL[31:3]; // control write
  logic [7:0] ctl; // shadow of control, since the checker cannot see it
  // shadow follows writes on the same edge as the real register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctl <= 8'h00;
    end else if (ctrl_wr) begin
      ctl <= i_reg_wdata[7:0];
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_stat_rd;
    i_reg_rd && stat_hit;
  endsequence
  sequence s_err_clr;
    i_reg_wr && stat_hit && i_reg_wdata[1] && !i_eng_err;
  endsequence
  // direct mode with control unchanged for a cycle, so pins have settled
  sequence s_steady;
    ctl[7] && ctl == $past(ctl);
  endsequence
  chk_rvalid_delay: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read answer missing");
  chk_busy_status: assert property (s_stat_rd ##0 $stable(i_eng_busy)
    |=> o_reg_rdata[0] == $past(i_eng_busy)) else $error("busy bit wrong");
  chk_err_raise: assert property (i_eng_err && ctl[0] |=> o_err_irq)
    else $error("error irq not raised");
  chk_err_gate: assert property (o_err_irq |-> ctl[0] || $past(ctl[0]))
    else $error("error irq while masked");
  chk_err_clear: assert property (s_err_clr |-> ##[1:2] !o_err_irq)
    else $error("error irq not cleared");
  chk_fin_raise: assert property ($fell(i_eng_busy) && ctl[1] |=> o_finish_irq)
    else $error("finish irq not raised");
  chk_fin_clear: assert property (s_stat_rd ##0 !$fell(i_eng_busy) |=> !o_finish_irq)
    else $error("finish irq not cleared");
  chk_fin_hold: assert property (o_finish_irq && !i_reg_rd |=> o_finish_irq)
    else $error("finish irq dropped");
  chk_direct_scl: assert property (s_steady |-> o_scl_oe && o_scl == ctl[6])
    else $error("clock pin wrong");
  chk_direct_sda: assert property (s_steady
    |-> o_sda_oe == ctl[5] && (!ctl[5] || o_sda == ctl[4])) else $error("data pin wrong");
endmodule
bind smbh_regs smbh_regs_checker #(.INST(INST)) u_chk (.i_clk_sys, .i_rst, .i_reg_addr,
  .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_eng_busy,
  .i_eng_err, .o_scl, .o_scl_oe, .o_sda, .o_sda_oe, .o_err_irq, .o_finish_irq);

//--- bench/testbench.sv
// self-checking bench for the register block, instance 0
// assumes the slave model resolves the data line
`timescale 1ns/1ps
module testbench;
  import smbh_pkg::*;
  localparam logic [31:0] FQ = SMBH_FREQ_OFF_0;
  localparam logic [31:0] CM = SMBH_CMD_OFF_0;
  localparam logic [31:0] ST = SMBH_STAT_OFF_0;
  localparam logic [31:0] CT = SMBH_CTRL_OFF_0;
  // stimulus, all valued at time zero
  logic i_clk_sys = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, hold_low = 0;
  logic [31:0] i_reg_addr = '0;
  logic [63:0] i_reg_wdata = '0;
  logic i_eng_busy = 0, i_eng_err = 0, i_eng_err_retry = 0;
  logic i_eng_scl_low = 0, i_eng_sda_low = 0, i_rx_valid = 0, i_rx_second = 0;
  logic [7:0] i_rx_byte = '0;
  logic [3:0] i_xfer_type = '0;
  logic i_xfer_ext = 0, i_serial_boot = 0, i_fetch_valid = 0, i_fetch_cs0 = 0, i_fetch_cs1 = 0;
  // observed
  logic [63:0] o_reg_rdata, rdv, v;
  logic [7:0] o_cmd_lo, o_cmd_hi, r[4];
  logic o_reg_rvalid, o_scl_ref, o_fetch_serial, o_fetch_generic, i_sda;
  logic o_scl, o_scl_oe, o_sda, o_sda_oe, o_err_irq, o_finish_irq;
  int errors = 0, n_checks = 0, ds[3] = '{0, 3, 31};
  smbh_regs #(.INST(0), .DIV_W(13)) u_smbh_regs (.i_clk_sys, .i_rst, .i_reg_addr, .i_reg_wr,
    .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_eng_busy, .i_eng_err,
    .i_eng_err_retry, .i_eng_scl_low, .i_eng_sda_low, .i_rx_valid, .i_rx_second, .i_rx_byte,
    .i_xfer_type, .i_xfer_ext, .o_cmd_lo, .o_cmd_hi, .o_scl_ref, .i_serial_boot,
    .i_fetch_valid, .i_fetch_cs0, .i_fetch_cs1, .o_fetch_serial, .o_fetch_generic, .i_sda,
    .o_scl, .o_scl_oe, .o_sda, .o_sda_oe, .o_err_irq, .o_finish_irq);
  smbh_slave_model u_smbh_slave_model (.i_sda(o_sda), .i_sda_oe(o_sda_oe),
    .i_hold_low(hold_low), .o_line(i_sda));
  always #12.5 i_clk_sys = ~i_clk_sys; // 40 MHz
  // expected reference period; a zero divider acts as one
  function automatic logic [63:0] per(int d);
    return 64'(8 * (d == 0 ? 1 : d));
  endfunction
  // expected status word: kind, error, busy; reserved bits zero
  function automatic logic [63:0] stw(logic b, logic e, logic k);
    return {61'h0, k, e, b};
  endfunction
  task automatic tick(int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // full-width write; strobe lasts one cycle
  task automatic wr(logic [31:0] a, logic [63:0] d);
    tick(1);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    tick(1);
    i_reg_wr = 0;
  endtask
  // read; answer stands in the cycle after the strobe
  task automatic rd(logic [31:0] a);
    tick(1);
    i_reg_addr = a;
    i_reg_rd = 1;
    tick(1);
    i_reg_rd = 0;
    chk("rvalid", 1'b1, o_reg_rvalid);
    rdv = o_reg_rdata;
  endtask
  // one received byte from the engine
  task automatic rx(logic s, logic [7:0] b, logic [3:0] t, logic e);
    tick(1);
    {i_rx_second, i_rx_byte, i_xfer_type, i_xfer_ext, i_rx_valid} = {s, b, t, e, 1'b1};
    tick(1);
    i_rx_valid = 0;
  endtask
  task automatic err(logic k);
    tick(1);
    {i_eng_err, i_eng_err_retry} = {1'b1, k};
    tick(1);
    i_eng_err = 0;
  endtask
  // time between two rising reference edges, after one edge to align
  task automatic measure(int d);
    int c;
    wr(FQ, 64'(d));
    repeat (2) begin
      c = 0;
      while (o_scl_ref !== 1'b0 && c < 30000) begin
        tick(1);
        c++;
      end
      while (o_scl_ref !== 1'b1 && c < 30000) begin
        tick(1);
        c++;
      end
    end
    chk("ref period", per(d), 64'(c));
  endtask
  task automatic final_report();
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the slowest divider dominates, a clean run needs under half
  initial begin
    #1_500_000;
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(28189));
    tick(3);
    i_rst = 0;
    rd(FQ);
    chk("div reset", {51'h0, SMBH_DIV_RST}, rdv);
    foreach (ds[i]) begin
      rd(i == 0 ? CT : i == 1 ? CM : 32'h1006_0048);
      chk("zero reset", 64'h0, rdv);
    end
    // random divider values, upper junk ignored
    repeat (4) begin
      v = {$urandom, $urandom};
      wr(FQ, v);
      rd(FQ);
      chk("divider", {51'h0, v[12:0]}, rdv);
    end
    // mid-run reset: a random divider may leave a very long half period
    i_rst = 1;
    tick(3);
    i_rst = 0;
    rd(FQ);
    chk("div rerst", {51'h0, SMBH_DIV_RST}, rdv);
    foreach (ds[i]) measure(ds[i]);
    measure(1250);
    // command bytes: outgoing, then captured per type
    v = 64'($urandom_range(16'hffff));
    foreach (r[i]) r[i] = 8'($urandom);
    wr(CM, v);
    tick(2);
    chk("cmd out", v[15:0], {o_cmd_hi, o_cmd_lo});
    rd(CM);
    chk("cmd rd", 64'h0, rdv);
    rx(0, r[0], SMBH_TYPE_RD2, 1);
    rx(1, r[1], SMBH_TYPE_RD2, 1);
    rx(0, r[2], SMBH_TYPE_RD1, 1);
    rx(1, r[3], SMBH_TYPE_RD1, 1);
    rx(0, ~r[2], SMBH_TYPE_RD2, 0);
    rd(CM);
    chk("cmd cap", {48'h0, r[1], r[2]}, rdv);
    // error with and without the enable
    wr(CT, 64'h1);
    err(1);
    tick(1);
    chk("err irq", 1'b1, o_err_irq);
    rd(ST);
    chk("err stat", stw(0, 1, 1), rdv);
    wr(ST, 64'h2);
    tick(2);
    chk("err clr", 1'b0, o_err_irq);
    wr(CT, 64'h0);
    err(0);
    tick(1);
    chk("err masked", 1'b0, o_err_irq);
    rd(ST);
    chk("err kind", stw(0, 1, 0), rdv);
    wr(ST, 64'h2);
    // completion
    wr(CT, 64'h2);
    i_eng_busy = 1;
    tick(3);
    rd(ST);
    chk("busy", stw(1, 0, 0), rdv);
    i_eng_busy = 0;
    tick(2);
    chk("fin irq", 1'b1, o_finish_irq);
    rd(ST);
    chk("idle", stw(0, 0, 0), rdv);
    chk("fin clr", 1'b0, o_finish_irq);
    // direct line control and line readback
    wr(CT, 64'hf0);
    tick(2);
    chk("pins", 4'hf, {o_scl, o_scl_oe, o_sda, o_sda_oe});
    wr(CT, 64'h90);
    hold_low = 1;
    tick(5);
    chk("pins off", 3'b010, {o_scl, o_scl_oe, o_sda_oe});
    rd(ST);
    chk("sda low", 1'b0, rdv[7]);
    chk("ref bit", o_scl_ref, rdv[6]);
    hold_low = 0;
    tick(5);
    rd(ST);
    chk("sda high", 1'b1, rdv[7]);
    wr(CT, 64'h0);
    {i_eng_scl_low, i_eng_sda_low} = 2'b11;
    tick(2);
    chk("engine pins", 4'h5, {o_scl, o_scl_oe, o_sda, o_sda_oe});
    rd(ST);
    chk("no direct", 2'b00, rdv[7:6]);
    // fetch routing: boot cs0, plain cs0, boot cs1
    foreach (ds[k]) begin
      {i_serial_boot, i_fetch_cs0, i_fetch_cs1} = {k != 1, k != 2, k == 2};
      tick(1);
      i_fetch_valid = 1;
      tick(1);
      i_fetch_valid = 0;
      chk("to serial", k == 0, o_fetch_serial);
      chk("to generic", k != 0, o_fetch_generic);
    end
    final_report();
  end
endmodule
